// [rtl/dsc_pkg.sv]
package dsc_pkg;

  // --------------------------------------------------------------
  // Register map, one bank of eight per serial input
  // --------------------------------------------------------------
  localparam logic [4:0]  IN_STRIDE    = 5'h08;
  localparam logic [4:0]  OFS_CTRL     = 5'h01;
  localparam logic [4:0]  OFS_DLY_RH   = 5'h02;
  localparam logic [4:0]  OFS_DLY_RL   = 5'h03;
  localparam logic [4:0]  OFS_DLY_LH   = 5'h04;
  localparam logic [4:0]  OFS_DLY_LL   = 5'h05;
  localparam logic [4:0]  OFS_FRAME    = 5'h06;
  localparam logic [4:0]  OFS_RJ_LEN   = 5'h07;
  localparam logic [4:0]  OFS_COMMIT   = 5'h08;
  localparam logic [4:0]  REG_LAST     = 5'h10;
  localparam logic [7:0]  REG_RST      = 8'h00;

  // --------------------------------------------------------------
  // Field positions and limits
  // --------------------------------------------------------------
  localparam int          MUTE_L_BIT   = 6;
  localparam int          MUTE_R_BIT   = 7;
  localparam int          FRAME_EN_BIT = 7;
  localparam int          FRAME_59_BIT = 6;
  localparam int          COMMIT_BIT   = 0;
  localparam logic [11:0] DLY_MAX      = 12'hfff;
  localparam logic [5:0]  RJ_MAX       = 6'h18;
  localparam logic [31:0] FR50_HZ      = 32'h32;
  localparam logic [31:0] FR59_NUM     = 32'h32;
  localparam logic [31:0] FR59_DEN     = 32'hbb5;
  localparam logic [7:0][17:0] FS_HZ   = {18'h2ee00, 18'h2ee00,
    18'h2b110, 18'h17700, 18'h15888, 18'h0bb80, 18'h0ac44, 18'h07d00};

  // --------------------------------------------------------------
  // Serial control port
  // --------------------------------------------------------------
  localparam logic [3:0]  I2C_ADDR_HI  = 4'h6;
  localparam logic [1:0]  STRAP_WAIT   = 2'h3;

  typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
    ST_WR, ST_WACK, ST_RD, ST_RACK} dsc_st_t;

  typedef logic [16:1][7:0] dsc_regs_t;

  typedef struct packed {
    logic [1:0]  fmt;
    logic [11:0] dly_l;
    logic [11:0] dly_r;
    logic [5:0]  rj_len;
  } dsc_set_t;

  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic [2:0] strap_m, strap_s, strap_q;
    logic [1:0] strap_n;
    dsc_st_t    st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw, nak, oe;
    logic [4:0] ptr;
    dsc_regs_t  regs;
    dsc_set_t [1:0] hold;
    logic [1:0] tog;
  } dsc_bus_q_t;

  typedef struct packed {
    logic [1:0] tog_m, tog_s, tog_p;
    logic [3:0] mute_m, mute_s;
    dsc_set_t [1:0] act;
    logic [1:0][11:0] fill_l, fill_r;
    logic [1:0] ml, mr;
  } dsc_lnk_q_t;

endpackage : dsc_pkg

// [rtl/dsc_commit.sv]
// Function
// - Commit bit one copies that input's pending settings in one step.
// - Copied settings are format, per-channel or frame delay, word length.
// - Commit byte with bit zero clear passes nothing; upper bits ignored.
// - After commit each channel mutes until its new delay has filled.
// - Format and word length changes wait for a commit.
// - Control mute bits act at once, with no commit.
// - Delay or format writes leave the datapath alone until commit.
// - Slave address low three bits come from the strap pins.
// - Sequential reads advance the register pointer after each byte.
// - Sequential writes store into consecutive registers.
// - Sample delay is at most 4095; larger frame delays are clamped.
// - Upper control bits mute left/right; lower two bits pick format.
`timescale 1ns/1ps
module dsc_commit (
  input  logic                     clk,
  input  logic                     rst_n,
  input  logic                     scl_i,
  input  logic                     sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  input  logic                     address_strap_lsb,
  input  logic                     address_strap_mid,
  input  logic                     address_strap_msb,
  input  logic                     aclk,
  input  logic [1:0]               smp_l,
  input  logic [1:0]               smp_r,
  output dsc_pkg::dsc_set_t [1:0]  act_set,
  output logic [1:0]               mute_l,
  output logic [1:0]               mute_r
);

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  function automatic logic is_commit(input logic [4:0] p);
    is_commit = (p == dsc_pkg::OFS_COMMIT) || (p == dsc_pkg::REG_LAST);
  endfunction : is_commit

  function automatic logic is_reg(input logic [4:0] p);
    is_reg = (p != 5'h00) && (p <= dsc_pkg::REG_LAST) && !is_commit(p);
  endfunction : is_reg

  // Commit registers are write-only and read back as zero.
  function automatic logic [7:0] rd_reg(input dsc_pkg::dsc_regs_t r,
                                        input logic [4:0] p);
    rd_reg = is_reg(p) ? r[p] : 8'h00;
  endfunction : rd_reg

  function automatic logic [11:0] clamp12(input logic [31:0] v);
    clamp12 = (v > 32'(dsc_pkg::DLY_MAX)) ? dsc_pkg::DLY_MAX : v[11:0];
  endfunction : clamp12

  function automatic logic [11:0] frame_dly(input logic [7:0] f);
    logic [31:0] n;
    n = (32'(f[2:0]) + 32'h1) * 32'(dsc_pkg::FS_HZ[f[5:3]]);
    if (f[dsc_pkg::FRAME_59_BIT]) begin
      frame_dly = clamp12(n * dsc_pkg::FR59_NUM / dsc_pkg::FR59_DEN);
    end else begin
      frame_dly = clamp12(n / dsc_pkg::FR50_HZ);
    end
  endfunction : frame_dly

  function automatic dsc_pkg::dsc_set_t build_set(
      input dsc_pkg::dsc_regs_t r, input logic k);
    dsc_pkg::dsc_set_t s;
    logic [4:0]        b;
    logic [7:0]        f;
    logic [5:0]        rj;
    b = k ? dsc_pkg::IN_STRIDE : 5'h00;
    f = r[b + dsc_pkg::OFS_FRAME];
    rj = r[b + dsc_pkg::OFS_RJ_LEN][5:0];
    s.fmt = r[b + dsc_pkg::OFS_CTRL][1:0];
    s.dly_r = clamp12({19'h0, r[b + dsc_pkg::OFS_DLY_RH][4:0],
                       r[b + dsc_pkg::OFS_DLY_RL]});
    s.dly_l = clamp12({19'h0, r[b + dsc_pkg::OFS_DLY_LH][4:0],
                       r[b + dsc_pkg::OFS_DLY_LL]});
    if (f[dsc_pkg::FRAME_EN_BIT]) begin
      s.dly_l = frame_dly(f);
      s.dly_r = s.dly_l;
    end
    s.rj_len = (rj > dsc_pkg::RJ_MAX) ? dsc_pkg::RJ_MAX : rj;
    build_set = s;
  endfunction : build_set

  // --------------------------------------------------------------
  // Control port domain
  // --------------------------------------------------------------
  dsc_pkg::dsc_bus_q_t bq, bd;
  logic                rise_w, fall_w, start_w, stop_w, wr_ev, addr_hit;
  logic [7:0]          rd_w;

  assign rise_w  = bq.scl_s & ~bq.scl_p;
  assign fall_w  = ~bq.scl_s & bq.scl_p;
  assign start_w = bq.scl_s & bq.scl_p & bq.sda_p & ~bq.sda_s;
  assign stop_w  = bq.scl_s & bq.scl_p & ~bq.sda_p & bq.sda_s;
  assign wr_ev   = fall_w && !start_w && !stop_w && bq.st == dsc_pkg::ST_WR
                   && bq.cnt == 4'h8;
  assign addr_hit = bq.sh[7:1] == {dsc_pkg::I2C_ADDR_HI, bq.strap_q};
  assign rd_w    = rd_reg(bq.regs, bq.ptr);

  always_comb begin
    bd = bq;
    bd.scl_m = scl_i;
    bd.scl_s = bq.scl_m;
    bd.scl_p = bq.scl_s;
    bd.sda_m = sda_i;
    bd.sda_s = bq.sda_m;
    bd.sda_p = bq.sda_s;
    bd.strap_m = {address_strap_msb, address_strap_mid, address_strap_lsb};
    bd.strap_s = bq.strap_m;
    // The strap is frozen once the synchroniser has filled after reset.
    if (bq.strap_n != dsc_pkg::STRAP_WAIT) begin
      bd.strap_n = bq.strap_n + 2'h1;
      bd.strap_q = bq.strap_s;
    end
    if (start_w) begin
      bd.st = dsc_pkg::ST_ADDR;
      bd.cnt = 4'h0;
      bd.oe = 1'b0;
    end else if (stop_w) begin
      bd.st = dsc_pkg::ST_IDLE;
      bd.oe = 1'b0;
    end else begin
      case (bq.st)
        dsc_pkg::ST_ADDR, dsc_pkg::ST_PTR, dsc_pkg::ST_WR: begin
          if (rise_w && bq.cnt != 4'h8) begin
            bd.sh = {bq.sh[6:0], bq.sda_s};
            bd.cnt = bq.cnt + 4'h1;
          end else if (fall_w && bq.cnt == 4'h8) begin
            bd.oe = 1'b1;
            if (bq.st == dsc_pkg::ST_ADDR) begin
              bd.rw = bq.sh[0];
              bd.st = addr_hit ? dsc_pkg::ST_AACK : dsc_pkg::ST_IDLE;
              bd.oe = addr_hit;
            end else if (bq.st == dsc_pkg::ST_PTR) begin
              bd.ptr = (bq.sh[7:5] == 3'h0) ? bq.sh[4:0] : 5'h00;
              bd.st = dsc_pkg::ST_PACK;
            end else begin
              if (is_reg(bq.ptr)) begin
                bd.regs[bq.ptr] = bq.sh;
              end
              if (is_commit(bq.ptr) && bq.sh[dsc_pkg::COMMIT_BIT]) begin
                bd.hold[bq.ptr[4]] = build_set(bq.regs, bq.ptr[4]);
                bd.tog[bq.ptr[4]] = ~bq.tog[bq.ptr[4]];
              end
              // Bit zero clear: the commit byte is simply dropped.
              bd.ptr = bq.ptr + 5'h1;
              bd.st = dsc_pkg::ST_WACK;
            end
          end
        end
        dsc_pkg::ST_AACK, dsc_pkg::ST_PACK, dsc_pkg::ST_WACK: begin
          if (fall_w) begin
            bd.oe = 1'b0;
            bd.cnt = 4'h0;
            bd.st = dsc_pkg::ST_WR;
            if (bq.st == dsc_pkg::ST_AACK) begin
              bd.st = bq.rw ? dsc_pkg::ST_RD : dsc_pkg::ST_PTR;
              bd.sh = rd_w;
              bd.oe = bq.rw & ~rd_w[7];
            end
          end
        end
        dsc_pkg::ST_RD: begin
          if (fall_w) begin
            if (bq.cnt == 4'h7) begin
              bd.oe = 1'b0;
              bd.ptr = bq.ptr + 5'h1;
              bd.st = dsc_pkg::ST_RACK;
            end else begin
              bd.sh = {bq.sh[6:0], 1'b0};
              bd.oe = ~bq.sh[6];
              bd.cnt = bq.cnt + 4'h1;
            end
          end
        end
        dsc_pkg::ST_RACK: begin
          if (rise_w) begin
            bd.nak = bq.sda_s;
          end else if (fall_w) begin
            // A not-acknowledge ends the read; the stop follows.
            bd.cnt = 4'h0;
            bd.sh = rd_w;
            bd.oe = ~bq.nak & ~rd_w[7];
            bd.st = bq.nak ? dsc_pkg::ST_IDLE : dsc_pkg::ST_RD;
          end
        end
        default: begin
          bd.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bq <= '0;
      bq.regs <= {16{dsc_pkg::REG_RST}};
    end else begin
      bq <= bd;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = bq.oe;

  // --------------------------------------------------------------
  // Audio link domain
  // --------------------------------------------------------------
  // The held settings stay still for microseconds between commits, so
  // sampling them after the toggle has crossed is safe.
  dsc_pkg::dsc_lnk_q_t lq, ld;
  logic                lrst_m, lrst_s;
  logic [1:0]          cm_ev;

  always_ff @(posedge aclk) begin
    lrst_m <= rst_n;
    lrst_s <= lrst_m;
  end

  assign cm_ev = lq.tog_s ^ lq.tog_p;

  always_comb begin
    ld = lq;
    ld.tog_m = bq.tog;
    ld.tog_s = lq.tog_m;
    ld.tog_p = lq.tog_s;
    ld.mute_m = {bq.regs[dsc_pkg::IN_STRIDE + dsc_pkg::OFS_CTRL][7:6],
                 bq.regs[dsc_pkg::OFS_CTRL][7:6]};
    ld.mute_s = lq.mute_m;
    for (int k = 0; k < 2; k++) begin
      if (cm_ev[k]) begin
        ld.act[k] = bq.hold[k];
        ld.fill_l[k] = bq.hold[k].dly_l;
        ld.fill_r[k] = bq.hold[k].dly_r;
      end else begin
        if (smp_l[k] && lq.fill_l[k] != 12'h000) begin
          ld.fill_l[k] = lq.fill_l[k] - 12'h001;
        end
        if (smp_r[k] && lq.fill_r[k] != 12'h000) begin
          ld.fill_r[k] = lq.fill_r[k] - 12'h001;
        end
      end
      ld.ml[k] = ld.mute_s[2*k] | (ld.fill_l[k] != 12'h000);
      ld.mr[k] = ld.mute_s[2*k+1] | (ld.fill_r[k] != 12'h000);
    end
  end

  always_ff @(posedge aclk) begin
    if (!lrst_s) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  assign act_set = lq.act;
  assign mute_l  = lq.ml;
  assign mute_r  = lq.mr;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  sequence s_addr_hit;
    fall_w && !start_w && !stop_w && bq.st == dsc_pkg::ST_ADDR
      && bq.cnt == 4'h8 && addr_hit;
  endsequence

  sequence s_commit_one;
    wr_ev && bq.ptr == dsc_pkg::OFS_COMMIT && bq.sh[dsc_pkg::COMMIT_BIT];
  endsequence

  a_addr_ack: assert property (@(posedge clk) disable iff (!rst_n)
    s_addr_hit |=> sda_oe && bq.st == dsc_pkg::ST_AACK)
    else $error("strapped address not acknowledged");

  a_commit_tog: assert property (@(posedge clk) disable iff (!rst_n)
    s_commit_one |=> bq.tog[0] != $past(bq.tog[0]) && $stable(bq.tog[1]))
    else $error("commit of input one did not launch");

  a_commit_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_ev && is_commit(bq.ptr) && !bq.sh[dsc_pkg::COMMIT_BIT])
      |=> $stable(bq.tog) && $stable(bq.hold))
    else $error("commit with bit zero clear changed settings");

  a_wr_incr: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ev |=> bq.ptr == $past(bq.ptr) + 5'h1 && bq.st == dsc_pkg::ST_WACK)
    else $error("write pointer did not advance");

  a_rd_incr: assert property (@(posedge clk) disable iff (!rst_n)
    (fall_w && !start_w && !stop_w && bq.st == dsc_pkg::ST_RD
      && bq.cnt == 4'h7) |=> bq.ptr == $past(bq.ptr) + 5'h1 && !sda_oe)
    else $error("read pointer did not advance");

  a_commit_load: assert property (@(posedge aclk) disable iff (!lrst_s)
    cm_ev[0] |=> act_set[0] == bq.hold[0])
    else $error("commit did not load input one settings");

  a_act_stable: assert property (@(posedge aclk) disable iff (!lrst_s)
    !cm_ev[1] |=> $stable(act_set[1]))
    else $error("settings changed without a commit");

  a_fill_mute: assert property (@(posedge aclk) disable iff (!lrst_s)
    (cm_ev[0] && bq.hold[0].dly_l != 12'h000) |=> mute_l[0]
      ##1 (mute_l[0] || lq.fill_l[0] == 12'h000))
    else $error("left channel not muted while delay fills");

  a_fill_count: assert property (@(posedge aclk) disable iff (!lrst_s)
    (!cm_ev[1] && smp_r[1] && lq.fill_r[1] != 12'h000)
      |=> lq.fill_r[1] == $past(lq.fill_r[1]) - 12'h001)
    else $error("right fill count did not step");

  a_mute_direct: assert property (@(posedge aclk) disable iff (!lrst_s)
    (lq.mute_s[1] |-> mute_r[0]) and
    ((!lq.mute_s[0] && lq.fill_l[0] == 12'h000) |-> !mute_l[0]))
    else $error("control mute not applied directly");

endmodule : dsc_commit

// [verif/dsc_i2c_host.sv]
`timescale 1ns/1ps
module dsc_i2c_host (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  // ------------------------------------------------------------
  // Bus controller model, open drain with pull-up
  // ------------------------------------------------------------
  logic sda_low;

  // The line is low while either party pulls it, else the pull-up wins.
  assign sda = !(sda_low || sda_oe);

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter bit of five clocks keeps each phase above the sync margin.
  task automatic q();
    repeat (5) @(posedge clk);
    #1;
  endtask : q

  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask : start

  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask : stop

  task automatic bit_w(input logic b);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    q();
    scl = 1'b0;
    q();
  endtask : bit_w

  task automatic bit_r(output logic b);
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    b = sda;
    q();
    scl = 1'b0;
    q();
  endtask : bit_r

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_w(d[i]);
    bit_r(a);
    ack = !a;
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_r(d[i]);
    bit_w(last);
  endtask : rbyte

  // Each bench has one device, so its strapped address is unique.
  task automatic wr_open(input logic [2:0] s, input logic [7:0] p,
                         output logic ack);
    logic a1;
    logic a2;
    start();
    wbyte({dsc_pkg::I2C_ADDR_HI, s, 1'b0}, a1);
    wbyte(p, a2);
    ack = a1 && a2;
  endtask : wr_open

  task automatic rd_open(input logic [2:0] s, input logic [7:0] p,
                         output logic ack);
    logic a1;
    logic a2;
    wr_open(s, p, a1);
    start();
    wbyte({dsc_pkg::I2C_ADDR_HI, s, 1'b1}, a2);
    ack = a1 && a2;
  endtask : rd_open
endmodule : dsc_i2c_host

// [verif/tb_delay_settings_commit.sv]
`timescale 1ns/1ps
module tb_delay_settings_commit;
  // ------------------------------------------------------------
  // Bench signals and tasks
  // ------------------------------------------------------------
  localparam logic [2:0] STRAP = 3'h1;
  logic                    clk, aclk, rst_n, scl, sda, sda_o, sda_oe;
  logic [1:0]              smp_l, smp_r, mute_l, mute_r;
  dsc_pkg::dsc_set_t [1:0] act_set;
  logic [7:0]              img [0:31];
  logic                    a;
  int                      mismatches, n_tests;

  dsc_commit i_dsc_commit (.clk(clk), .rst_n(rst_n), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_strap_lsb(STRAP[0]), .address_strap_mid(STRAP[1]),
    .address_strap_msb(STRAP[2]), .aclk(aclk), .smp_l(smp_l),
    .smp_r(smp_r), .act_set(act_set), .mute_l(mute_l), .mute_r(mute_r));

  dsc_i2c_host i_dsc_i2c_host (.clk(clk), .sda_oe(sda_oe), .scl(scl),
    .sda(sda));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    aclk = 1'b0;
    #1.3;
    forever #3 aclk = ~aclk;
  end

  task automatic check(input string w, input logic [63:0] s,
                       input logic [63:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", w, e, s);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // The image tracks what the host stored; commit bytes are not kept.
  task automatic wr(input logic [4:0] p, input int n, input logic [63:0] d);
    logic [7:0] b;
    logic [4:0] r;
    i_dsc_i2c_host.wr_open(STRAP, {3'h0, p}, a);
    check("ack", a, 1);
    for (int i = 0; i < n; i++) begin
      b = d[8*(n-1-i) +: 8];
      r = p + i[4:0];
      i_dsc_i2c_host.wbyte(b, a);
      check("ack", a, 1);
      if (r != 5'h08 && r != 5'h10) img[r] = b;
    end
    i_dsc_i2c_host.stop();
    repeat (20) @(posedge aclk);
  endtask : wr

  task automatic rd_chk(input logic [4:0] p, input int n);
    logic [7:0] d;
    logic [4:0] r;
    i_dsc_i2c_host.rd_open(STRAP, {3'h0, p}, a);
    check("ack", a, 1);
    for (int i = 0; i < n; i++) begin
      r = p + i[4:0];
      i_dsc_i2c_host.rbyte(i == n - 1, d);
      check("rd", d, (r == 5'h08 || r == 5'h10) ? 8'h00 : img[r]);
    end
    i_dsc_i2c_host.stop();
  endtask : rd_chk

  task automatic pulses(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      #1;
      smp_l[k] = 1'b1;
      smp_r[k] = 1'b1;
      @(posedge aclk);
      #1;
      smp_l = 2'h0;
      smp_r = 2'h0;
    end
    repeat (6) @(posedge aclk);
  endtask : pulses

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    smp_l = 2'h0;
    smp_r = 2'h0;
    mismatches = 0;
    n_tests = 0;
    for (int i = 0; i < 32; i++) img[i] = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge clk);
    check("act", act_set, 64'h0);
    check("mute", {mute_l, mute_r}, 4'h0);
    check("sda_o", sda_o, 0);
    rd_chk(5'h01, 16);
    $display("test reset done");
    i_dsc_i2c_host.wr_open(3'h2, 8'h01, a);
    i_dsc_i2c_host.stop();
    check("ack", a, 0);
    $display("test address done");
    // Right justified, right delay 3, left delay 5, word length 16.
    wr(5'h01, 7, {8'h01, 8'h00, 8'h03, 8'h00, 8'h05, 8'h00, 8'h10});
    check("act0", act_set[0], 32'h0);
    rd_chk(5'h01, 8);
    wr(5'h08, 1, 64'hfe);
    check("act0", act_set[0], 32'h0);
    wr(5'h08, 1, 64'h01);
    check("act0", act_set[0], {2'h1, 12'h005, 12'h003, 6'h10});
    check("act1", act_set[1], 32'h0);
    check("mute", {mute_l[0], mute_r[0]}, 2'h3);
    pulses(0, 3);
    check("mute", {mute_l[0], mute_r[0]}, 2'h2);
    pulses(0, 2);
    check("mute", {mute_l[0], mute_r[0]}, 2'h0);
    $display("test commit done");
    // Format 3 is written with each mute code but not committed here.
    for (int i = 0; i < 4; i++) begin
      wr(5'h01, 1, {56'h0, i[1:0], 6'h03});
      check("mute_l", mute_l[0], i[0]);
      check("mute_r", mute_r[0], i[1]);
      check("fmt", act_set[0].fmt, 2'h1);
    end
    rd_chk(5'h01, 1);
    $display("test mute done");
    // Eight frames at 50 Hz and 48 kHz exceed the delay limit.
    wr(5'h0e, 2, {8'h97, 8'h3f});
    wr(5'h09, 1, 64'h02);
    wr(5'h10, 1, 64'h01);
    check("act1", act_set[1], {2'h2, dsc_pkg::DLY_MAX, dsc_pkg::DLY_MAX,
      dsc_pkg::RJ_MAX});
    check("act0", act_set[0], {2'h1, 12'h005, 12'h003, 6'h10});
    check("mute1", {mute_l[1], mute_r[1]}, 2'h3);
    // The clamped delay releases the mute on exactly the last sample.
    pulses(1, 4094);
    check("mute1", {mute_l[1], mute_r[1]}, 2'h3);
    pulses(1, 1);
    check("mute1", {mute_l[1], mute_r[1]}, 2'h0);
    wr(5'h09, 1, 64'h83);
    check("mute1", {mute_l[1], mute_r[1]}, 2'h1);
    check("fmt1", act_set[1].fmt, 2'h2);
    // One frame at 59.94 Hz and 32 kHz; the pending bypass format lands.
    wr(5'h06, 1, 64'hc0);
    wr(5'h08, 1, 64'h01);
    check("act0", act_set[0],
      {2'h3, 12'h215, 12'h215, 6'h10});
    check("act1", act_set[1], {2'h2, dsc_pkg::DLY_MAX, dsc_pkg::DLY_MAX,
      dsc_pkg::RJ_MAX});
    $display("test frame done");
    results();
  end
endmodule : tb_delay_settings_commit
